// *** dv/codec_model.sv ***
`timescale 1ns/1ns
// far-side codec: supplies the transmit pin clock and catches one word
module codec_model (
  input  wire       pclk,
  input  wire       tx_data,
  output reg        tx_clock_in,
  output reg        rx_clock_in,
  output reg        tx_frame_sync_in,
  output reg  [7:0] got
);
  integer nbits;
  // idle high so the first edge of a frame is a fall; clock stands between frames
  initial begin
    tx_clock_in = 1'b1;
    rx_clock_in = 1'b1;
    tx_frame_sync_in = 1'b0;
    got = 8'h00;
    nbits = 0;
  end
  // half period of 8 bus clocks stays under bus clock over six
  task run(input integer n);
    integer i;
    begin
      for (i = 0; i < 2 * n; i = i + 1) begin
        repeat (8) @(posedge pclk);
        tx_clock_in <= ~tx_clock_in;
      end
    end
  endtask
  task clear;
    begin
      nbits = 0;
      got = 8'h00;
    end
  endtask
  // lsb first; samples past one word are ignored
  always @(posedge tx_clock_in) begin
    if (nbits < 8) begin
      got = {tx_data, got[7:1]};
      nbits = nbits + 1;
    end
  end
endmodule

// *** dv/sync_serial_tx_properties.sv ***
`timescale 1ns/1ns
`include "ssc_tx_consts.vh"
module sync_serial_tx_properties (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tx_clock_oe,
  input wire        rx_clock_out,
  input wire        rx_clock_oe,
  input wire        rx_start,
  input wire        irq
);
  reg  [11:0] div_q;
  reg  [9:0]  rcm_q;
  reg  [2:0]  ctrl_q;
  reg  [15:0] run_q;
  reg  [3:0]  age_q;
  reg         seen_q;
  reg         prev_q;
  wire        wr;
  wire        cfg;
  wire        tog;
  assign wr  = psel && penable && pready && pwrite;
  assign cfg = wr && (paddr == `DIV_ADDR || paddr == `RCM_ADDR);
  assign tog = rx_clock_out != prev_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow config; a divider or receive clock mode write restarts phase and age counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 12'h000;
      rcm_q  <= 10'h000;
      ctrl_q <= 3'h0;
      run_q  <= 16'h0000;
      age_q  <= 4'h0;
      seen_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= rx_clock_out;
      if (wr && paddr == `DIV_ADDR) div_q <= pwdata[11:0];
      if (wr && paddr == `RCM_ADDR) rcm_q <= pwdata[9:0];
      if (wr && paddr == `CTRL_ADDR) ctrl_q <= pwdata[2:0];
      if (cfg) begin
        run_q  <= 16'h0000;
        age_q  <= 4'h0;
        seen_q <= 1'b0;
      end else begin
        run_q  <= tog ? 16'h0001 : run_q + 16'h0001;
        age_q  <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
        seen_q <= seen_q | tog;
      end
    end
  end
  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  phase_len_a: assert property (
    tog && seen_q && rcm_q[1:0] == `CKS_DIV |-> run_q == {4'h0, div_q})
    else $error("divided clock phase length wrong");
  div_idle_a: assert property (
    div_q == 12'h000 && rcm_q[1:0] == `CKS_DIV && age_q > 4'h4 |-> !rx_clock_out)
    else $error("divider runs with zero setting");
  rx_cont_oe_a: assert property (
    wr && paddr == `RCM_ADDR && pwdata[4:2] == `CKO_CONT |-> ##[1:3] rx_clock_oe)
    else $error("receive clock pin not driven");
  tx_none_oe_a: assert property (
    wr && paddr == `TCM_ADDR && pwdata[4:2] == `CKO_NONE |-> ##3 (!tx_clock_oe) [*4])
    else $error("transmit clock pin driven in mode none");
  irq_gate_a: assert property (
    !ctrl_q[`IRQEN_BIT] && !$past(ctrl_q[`IRQEN_BIT]) |-> !irq)
    else $error("irq while disabled");
  rx_start_a: assert property (
    wr && paddr == `CTRL_ADDR && pwdata[`RXEN_BIT] && !ctrl_q[`RXEN_BIT]
    && rcm_q[9:8] == `ST_CONT |-> ##[1:4] rx_start)
    else $error("no receive start on enable");
  cover property (pslverr);
  cover property (tog && seen_q && rcm_q[1:0] == `CKS_DIV);
  cover property (rx_start);
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
`include "ssc_tx_consts.vh"
module tb_top;
  reg         pclk, presetn, psel, penable, pwrite, rx_seen, e, rx_busy;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, q;
  wire [31:0] prdata;
  wire        pready, pslverr, tx_clock_in, tx_clock_out, tx_clock_oe, rx_clock_in;
  wire        rx_clock_out, rx_clock_oe, tx_frame_sync_in, tx_data, rx_bit_clock;
  wire        tx_frame_sync_out, tx_frame_sync_oe, rx_start, irq;
  wire [7:0]  word;
  integer     mismatches, n_checks, cyc, tt, tr, nd;
  sync_serial_tx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clock_in(tx_clock_in), .tx_clock_out(tx_clock_out),
    .tx_clock_oe(tx_clock_oe), .rx_clock_in(rx_clock_in), .rx_clock_out(rx_clock_out),
    .rx_clock_oe(rx_clock_oe), .tx_frame_sync_in(tx_frame_sync_in),
    .tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe(tx_frame_sync_oe),
    .tx_data(tx_data), .rx_start_in(1'b0), .rx_busy_in(rx_busy),
    .rx_bit_clock(rx_bit_clock), .rx_start(rx_start), .irq(irq));
  codec_model codec (.pclk(pclk), .tx_data(tx_data), .tx_clock_in(tx_clock_in),
    .rx_clock_in(rx_clock_in), .tx_frame_sync_in(tx_frame_sync_in), .got(word));
  always #10 pclk = ~pclk;
  // hang guard plus sticky catch of the one-cycle receive start pulse
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rx_start === 1'b1) rx_seen <= 1'b1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // one apb transfer; idle cycle after so psel never toggles twice in a step
  // no wait limit here: only the bench's cycle ceiling ends a hung access
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, input err);
    begin
      apb(a, 1'b0, 32'h00000000);
      chk("rdata", exp, q);
      chk("slverr", 32'(err), 32'(e));
    end
  endtask
  // toggle counts over 24 cycles; a period of 6 gives exactly 8
  task watch;
    integer i;
    reg pt, pr;
    begin
      tt = 0; tr = 0; nd = 0; pt = tx_clock_out; pr = rx_clock_out;
      for (i = 0; i < 24; i = i + 1) begin
        @(posedge pclk);
        if (tx_clock_out !== pt) tt = tt + 1;
        if (rx_clock_out !== pr) tr = tr + 1;
        if (rx_bit_clock !== rx_clock_out) nd = nd + 1;
        pt = tx_clock_out; pr = rx_clock_out;
      end
    end
  endtask
  task t_reset;
    begin
      rd(`STAT_ADDR, 32'h00000003, 1'b0);
      apb(`STAT_ADDR, 1'b1, 32'h00000000);
      rd(`STAT_ADDR, 32'h00000003, 1'b0);
      rd(8'h20, 32'h00000000, 1'b1);
      apb(`DIV_ADDR, 1'b1, 32'hffffffff);
      rd(`DIV_ADDR, 32'h00000fff, 1'b0);
    end
  endtask
  task t_divider;
    begin
      apb(`DIV_ADDR, 1'b1, 32'h00000003);
      apb(`TCM_ADDR, 1'b1, 32'h00000004);
      apb(`RCM_ADDR, 1'b1, 32'h00000004);
      watch;
      chk("txtog", 32'h8, 32'(tt));
      chk("rxtog", 32'h8, 32'(tr));
      chk("txoe", 32'h1, 32'(tx_clock_oe));
      chk("rxoe", 32'h1, 32'(rx_clock_oe));
      chk("bitclk", 32'h1, 32'(nd <= 8));
      apb(`RCM_ADDR, 1'b1, 32'h00000025);
      apb(`TCM_ADDR, 1'b1, 32'h00000024);
      watch;
      chk("rxoth", 32'h8, 32'(tr));
      chk("txinv", 32'h8, 32'(tt));
      chk("invclk", 32'h1, 32'(nd >= 16));
      apb(`DIV_ADDR, 1'b1, 32'h00000000);
      repeat (10) @(posedge pclk);
      watch;
      chk("idle", 32'h0, 32'(tr + rx_clock_out));
    end
  endtask
  task t_transmit;
    begin
      apb(`RCM_ADDR, 1'b1, 32'h00000000);
      apb(`TFM_ADDR, 1'b1, 32'h00000007);
      apb(`TCM_ADDR, 1'b1, 32'h0000000a);
      apb(`CTRL_ADDR, 1'b1, 32'h00000007);
      rd(`STAT_ADDR, 32'h00000003, 1'b0);
      chk("irq", 32'h1, 32'(irq));
      chk("rxstart", 32'h1, 32'(rx_seen));
      codec.clear;
      apb(`THR_ADDR, 1'b1, 32'h000000a5);
      rd(`STAT_ADDR, 32'h00000000, 1'b0);
      chk("irqoff", 32'h0, 32'(irq));
      codec.run(1);
      rd(`STAT_ADDR, 32'h00000001, 1'b0);
      chk("xferoe", 32'h1, 32'(tx_clock_oe));
      codec.run(8);
      repeat (8) @(posedge pclk);
      rd(`STAT_ADDR, 32'h00000003, 1'b0);
      chk("word", 32'h000000a5, {24'h000000, word});
      chk("txidle", 32'h0, 32'(tx_data));
      apb(`TCM_ADDR, 1'b1, 32'h00000000);
      repeat (4) @(posedge pclk);
      chk("nooe", 32'h0, 32'(tx_clock_oe));
      chk("fsoe", 32'h0, 32'(tx_frame_sync_oe));
      chk("fsout", 32'h0, 32'(tx_frame_sync_out));
      // receive pin driven only while the receive section reports a transfer
      apb(`RCM_ADDR, 1'b1, 32'h00000008);
      rx_busy <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("rxxferoe", 32'h1, 32'(rx_clock_oe));
      rx_busy <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("rxidleoe", 32'h0, 32'(rx_clock_oe));
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; rx_seen = 1'b0; rx_busy = 1'b0;
    mismatches = 0; n_checks = 0; cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_divider;
    t_transmit;
    results;
  end
endmodule
bind sync_serial_tx sync_serial_tx_properties props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .tx_clock_oe(tx_clock_oe),
  .rx_clock_out(rx_clock_out), .rx_clock_oe(rx_clock_oe), .rx_start(rx_start), .irq(irq));

// *** rtl/ssc_tx_consts.vh ***
`ifndef SSC_TX_CONSTS_VH
`define SSC_TX_CONSTS_VH

// register byte offsets
`define DIV_ADDR    8'h00
`define TCM_ADDR    8'h04
`define RCM_ADDR    8'h08
`define TFM_ADDR    8'h0c
`define THR_ADDR    8'h10
`define STAT_ADDR   8'h14
`define CTRL_ADDR   8'h18
`define TSYNC_ADDR  8'h1c

// writable bit masks per register
`define DIV_MASK    32'h00000fff
`define CM_MASK     32'h0000033f
`define TFM_MASK    32'h0f9f009f
`define CTRL_MASK   32'h00000007
`define ZERO32      32'h00000000

// clock mode register fields
`define CKS_LO      0
`define CKS_HI      1
`define CKO_LO      2
`define CKO_HI      4
`define CKI_BIT     5
`define ST_LO       8
`define ST_HI       9

// clock source codes
`define CKS_DIV     2'h0
`define CKS_OTHER   2'h1
`define CKS_PIN     2'h2

// clock output mode codes
`define CKO_NONE    3'h0
`define CKO_CONT    3'h1
`define CKO_XFER    3'h2

// start event codes
`define ST_CONT     2'h0
`define ST_OTHER    2'h1
`define ST_FS_RISE  2'h2
`define ST_FS_FALL  2'h3

// transmit frame mode fields
`define DLEN_LO     0
`define DLEN_HI     4
`define MSBF_BIT    7
`define SLO_LO      16
`define SLO_HI      19
`define FSOE_BIT    20
`define FSDEN_BIT   23
`define SHI_LO      24
`define SHI_HI      27

// status and control bits
`define READY_BIT   0
`define EMPTY_BIT   1
`define TXEN_BIT    0
`define RXEN_BIT    1
`define IRQEN_BIT   2

`endif

// *** rtl/sync_serial_tx.v ***
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "ssc_tx_consts.vh"

module sync_serial_tx #(
  parameter DIV_W = 12
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        tx_clock_in,
  output reg         tx_clock_out,
  output reg         tx_clock_oe,
  input  wire        rx_clock_in,
  output reg         rx_clock_out,
  output reg         rx_clock_oe,
  input  wire        tx_frame_sync_in,
  output reg         tx_frame_sync_out,
  output reg         tx_frame_sync_oe,
  output reg         tx_data,
  input  wire        rx_start_in,
  input  wire        rx_busy_in,
  output reg         rx_bit_clock,
  output reg         rx_start,
  output reg         irq
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_SYNC = 3'b010;
  localparam [2:0] S_DATA = 3'b100;

  // software registers
  reg [31:0]      div_mode_q;
  reg [31:0]      tx_mode_q;
  reg [31:0]      rx_mode_q;
  reg [31:0]      frame_mode_q;
  reg [31:0]      hold_q;
  reg [31:0]      tsync_q;
  reg [31:0]      ctrl_q;
  reg             hold_full_q;

  // clocking state
  reg [DIV_W-1:0] div_cnt_q;
  reg             div_clk_q;
  reg             txp_s1_q;
  reg             txp_s2_q;
  reg             rxp_s1_q;
  reg             rxp_s2_q;
  reg             fs_s1_q;
  reg             fs_s2_q;
  reg             fs_s3_q;
  reg             tx_bit_prev_q;
  reg             rxen_prev_q;

  // transmit path state
  reg [2:0]       state_q;
  reg [2:0]       state_d;
  reg [31:0]      shift_q;
  reg [31:0]      shift_d;
  reg [7:0]       bits_q;
  reg [7:0]       bits_d;
  reg             pend_q;
  reg             load_hold;

  wire            wr_done;
  wire            rd_setup;
  wire            txen;
  wire [DIV_W-1:0] div_n;
  wire [1:0]      tx_cks;
  wire [1:0]      rx_cks;
  wire [2:0]      tx_cko;
  wire [2:0]      rx_cko;
  wire [1:0]      tx_st;
  wire [1:0]      rx_st;
  wire [4:0]      dlen;
  wire [7:0]      sync_len;
  wire            tx_base;
  wire            rx_base;
  wire            tx_lvl;
  wire            rx_lvl;
  wire            tx_bit;
  wire            fall_evt;
  wire            fs_rise;
  wire            fs_fall;
  wire            start_evt;
  wire            busy;
  wire            rx_go;
  reg  [31:0]     rd_mux;
  reg             rd_bad;
  reg  [31:0]     rev_word;
  integer         i;

  // a write lands only at the edge that completes the access
  assign wr_done  = psel & penable & pready & pwrite;
  assign rd_setup = psel & penable & ~pready;
  assign txen     = ctrl_q[`TXEN_BIT];

  assign div_n    = div_mode_q[DIV_W-1:0];
  assign tx_cks   = tx_mode_q[`CKS_HI:`CKS_LO];
  assign rx_cks   = rx_mode_q[`CKS_HI:`CKS_LO];
  assign tx_cko   = tx_mode_q[`CKO_HI:`CKO_LO];
  assign rx_cko   = rx_mode_q[`CKO_HI:`CKO_LO];
  assign tx_st    = tx_mode_q[`ST_HI:`ST_LO];
  assign rx_st    = rx_mode_q[`ST_HI:`ST_LO];
  assign dlen     = frame_mode_q[`DLEN_HI:`DLEN_LO];
  assign sync_len = {frame_mode_q[`SHI_HI:`SHI_LO], frame_mode_q[`SLO_HI:`SLO_LO]};

  // register read decode, unmapped or unaligned offsets give an error
  always @* begin
    rd_mux = `ZERO32;
    rd_bad = 1'b0;
    case (paddr)
      `DIV_ADDR:   rd_mux = div_mode_q;
      `TCM_ADDR:   rd_mux = tx_mode_q;
      `RCM_ADDR:   rd_mux = rx_mode_q;
      `TFM_ADDR:   rd_mux = frame_mode_q;
      `THR_ADDR:   rd_mux = hold_q;
      `STAT_ADDR: begin
        rd_mux[`READY_BIT] = ~hold_full_q;
        rd_mux[`EMPTY_BIT] = ~hold_full_q & (state_q == S_IDLE);
      end
      `CTRL_ADDR:  rd_mux = ctrl_q;
      `TSYNC_ADDR: rd_mux = tsync_q;
      default:     rd_bad = 1'b1;
    endcase
  end

  // one wait state so read data and pready come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & rd_bad;
      if (rd_setup & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // configuration writes, masked so reserved bits read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_mode_q   <= `ZERO32;
      tx_mode_q    <= `ZERO32;
      rx_mode_q    <= `ZERO32;
      frame_mode_q <= `ZERO32;
      tsync_q      <= `ZERO32;
      ctrl_q       <= `ZERO32;
    end else if (wr_done) begin
      case (paddr)
        `DIV_ADDR:   div_mode_q   <= pwdata & `DIV_MASK;
        `TCM_ADDR:   tx_mode_q    <= pwdata & `CM_MASK;
        `RCM_ADDR:   rx_mode_q    <= pwdata & `CM_MASK;
        `TFM_ADDR:   frame_mode_q <= pwdata & `TFM_MASK;
        `CTRL_ADDR:  ctrl_q       <= pwdata & `CTRL_MASK;
        `TSYNC_ADDR: tsync_q      <= pwdata;
        default: ;
      endcase
    end
  end

  // shared divider, toggles every N cycles so odd N keeps 50% duty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= {DIV_W{1'b0}};
      div_clk_q <= 1'b0;
    end else if (div_n == {DIV_W{1'b0}}) begin
      div_cnt_q <= {DIV_W{1'b0}};
      div_clk_q <= 1'b0;
    end else if (div_cnt_q >= div_n - 1'b1) begin
      div_cnt_q <= {DIV_W{1'b0}};
      div_clk_q <= ~div_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // pin synchronizers; the clock pins use the second stage, frame sync the second and third
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txp_s1_q <= 1'b0;
      txp_s2_q <= 1'b0;
      rxp_s1_q <= 1'b0;
      rxp_s2_q <= 1'b0;
      fs_s1_q  <= 1'b0;
      fs_s2_q  <= 1'b0;
      fs_s3_q  <= 1'b0;
    end else begin
      txp_s1_q <= tx_clock_in;
      txp_s2_q <= txp_s1_q;
      rxp_s1_q <= rx_clock_in;
      rxp_s2_q <= rxp_s1_q;
      fs_s1_q  <= tx_frame_sync_in;
      fs_s2_q  <= fs_s1_q;
      fs_s3_q  <= fs_s2_q;
    end
  end

  // the cross options take the other side's base source, so no loop
  assign tx_base = (tx_cks == `CKS_PIN) ? txp_s2_q : div_clk_q;
  assign rx_base = (rx_cks == `CKS_PIN) ? rxp_s2_q : div_clk_q;
  assign tx_lvl  = (tx_cks == `CKS_OTHER) ? rx_base : tx_base;
  assign rx_lvl  = (rx_cks == `CKS_OTHER) ? tx_base : rx_base;
  assign tx_bit  = tx_lvl ^ tx_mode_q[`CKI_BIT];

  assign fall_evt = tx_bit_prev_q & ~tx_bit;
  assign fs_rise  = fs_s2_q & ~fs_s3_q;
  assign fs_fall  = ~fs_s2_q & fs_s3_q;
  assign busy     = (state_q != S_IDLE);
  assign rx_go    = ctrl_q[`RXEN_BIT] & ~rxen_prev_q;

  // latched start events for the non-continuous modes
  assign start_evt = ((tx_st == `ST_OTHER) & rx_start_in) |
                     ((tx_st == `ST_FS_RISE) & fs_rise) |
                     ((tx_st == `ST_FS_FALL) & fs_fall);

  // bit-reverse within the word length for msb-first sending
  always @* begin
    rev_word = `ZERO32;
    for (i = 0; i < 32; i = i + 1) begin
      if (i <= dlen) begin
        rev_word[i] = hold_q[dlen - i[4:0]];
      end
    end
  end

  // transmit sequencer, steps on falling edges of the bit clock
  always @* begin
    state_d   = state_q;
    shift_d   = shift_q;
    bits_d    = bits_q;
    load_hold = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (fall_evt & hold_full_q &
            ((tx_st == `ST_CONT) | pend_q)) begin
          if (frame_mode_q[`FSDEN_BIT]) begin
            state_d = S_SYNC;
            shift_d = tsync_q;
            bits_d  = sync_len;
          end else begin
            state_d   = S_DATA;
            load_hold = 1'b1;
          end
        end
      end
      S_SYNC: begin
        if (fall_evt) begin
          if (bits_q == 8'h00) begin
            state_d   = S_DATA;
            load_hold = 1'b1;
          end else begin
            bits_d  = bits_q - 8'h01;
            shift_d = {1'b0, shift_q[31:1]};
          end
        end
      end
      S_DATA: begin
        if (fall_evt) begin
          if (bits_q == 8'h00) begin
            if (hold_full_q) begin
              load_hold = 1'b1;
            end else begin
              state_d = S_IDLE;
            end
          end else begin
            bits_d  = bits_q - 8'h01;
            shift_d = {1'b0, shift_q[31:1]};
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (load_hold) begin
      shift_d = frame_mode_q[`MSBF_BIT] ? rev_word : hold_q;
      bits_d  = {3'h0, dlen};
    end
  end

  // transmit registers and holding buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= S_IDLE;
      shift_q       <= `ZERO32;
      bits_q        <= 8'h00;
      pend_q        <= 1'b0;
      hold_q        <= `ZERO32;
      hold_full_q   <= 1'b0;
      tx_bit_prev_q <= 1'b0;
      tx_data       <= 1'b0;
    end else begin
      tx_bit_prev_q <= tx_bit;
      if (!txen) begin
        state_q <= S_IDLE;
        pend_q  <= 1'b0;
        tx_data <= 1'b0;
      end else begin
        state_q <= state_d;
        shift_q <= shift_d;
        bits_q  <= bits_d;
        // a start arriving as the pending one is used is kept
        if (start_evt) begin
          pend_q <= 1'b1;
        end else if (state_q == S_IDLE && state_d != S_IDLE) begin
          pend_q <= 1'b0;
        end
        if (fall_evt) begin
          tx_data <= (state_d == S_IDLE) ? 1'b0 : shift_d[0];
        end
      end
      // a write in the moving cycle refills the holding register
      if (wr_done && paddr == `THR_ADDR) begin
        hold_q      <= pwdata;
        hold_full_q <= 1'b1;
      end else if (load_hold && txen) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  // pin drivers follow the uninverted clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clock_out      <= 1'b0;
      tx_clock_oe       <= 1'b0;
      rx_clock_out      <= 1'b0;
      rx_clock_oe       <= 1'b0;
      rx_bit_clock      <= 1'b0;
      rx_start          <= 1'b0;
      rxen_prev_q       <= 1'b0;
      tx_frame_sync_out <= 1'b0;
      tx_frame_sync_oe  <= 1'b0;
      irq               <= 1'b0;
    end else begin
      tx_clock_out <= tx_lvl;
      tx_clock_oe  <= (tx_cko == `CKO_CONT) |
                      ((tx_cko == `CKO_XFER) & busy);
      rx_clock_out <= rx_lvl;
      rx_clock_oe  <= (rx_cko == `CKO_CONT) |
                      ((rx_cko == `CKO_XFER) & rx_busy_in);
      rx_bit_clock <= rx_lvl ^ rx_mode_q[`CKI_BIT];
      rxen_prev_q  <= ctrl_q[`RXEN_BIT];
      rx_start     <= ((rx_st == `ST_CONT) & rx_go) |
                      ((rx_st == `ST_OTHER) & txen & fall_evt &
                       (state_q == S_IDLE) & (state_d != S_IDLE));
      tx_frame_sync_out <= (state_q == S_SYNC);
      tx_frame_sync_oe  <= frame_mode_q[`FSOE_BIT];
      irq <= ctrl_q[`IRQEN_BIT] & ~hold_full_q;
    end
  end

endmodule
